// ### src/carer_core.v
// store queue, scratchpad and tick-compare error checking and reporting
`timescale 1ns/10ps
`include "carer_regs.vh"
//
// Operation
// - store-queue data ECC, tag CAM single parity
// - diagnostic store-queue reads never flag errors
// - load correctable needs enable; forwarded data uncorrected
// - load correctable: precise status, index, trap
// - precise-class errors without enable record nothing
// - load uncorrectable: record code, index, trap
// - no CAM parity check on loads
// - drain correctable: correct data, log disrupting
// - corrected trap under enable and interrupt condition
// - pending valid flag re-presents trap later
// - drain uncorrectable to memory poisons data, logs
// - sw-recoverable trap under enable, also later
// - io/ring uncorrectable suppresses strand stores, deferred trap
// - record highest privilege of queued stores
// - tag parity error suppresses, deferred trap
// - scratchpad checked on normal reads only
// - scratchpad correctable: code, index, syndrome, trap
// - scratchpad uncorrectable: code, index, no syndrome
// - writes generate fresh check bits
// - three tick compares, cycled regardless of enables; scan holds during reads
// - tick correctable on read: code, index, syndrome
// - tick uncorrectable on read: code, index, syndrome
// - compare error suppresses compare, logs disrupting
// - compare log needs recording enable; trap when enabled
// - recording enables reset to zero
// - precise and disrupting traps need recording and trap enable; deferred trap needs recording enable only
// - precise registers update only on taken trap
module carer_core (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // strand state (same clock)
    input wire interrupt_enable,
    input wire hyperprivileged_flag,
    // store queue access
    input wire sq_load_hit,
    input wire sq_drain,
    input wire sq_drain_io,
    input wire sq_ring,
    input wire sq_diag,
    input wire [2:0] sq_index,
    input wire [63:0] sq_data,
    input wire [7:0] sq_check,
    input wire [39:0] sq_tag,
    input wire sq_tag_par,
    input wire [3:0] sq_priv_valid,
    input wire [1:0] sq_priv_max,
    // store queue outputs
    output reg [63:0] sq_out_data,
    output reg sq_out_poison,
    output reg sq_out_valid,
    output reg sq_suppress,
    // scratchpad access
    input wire sp_read,
    input wire sp_diag,
    input wire [2:0] sp_index,
    input wire [63:0] sp_data,
    input wire [7:0] sp_check,
    // write check generation
    input wire [63:0] wr_data,
    output reg [7:0] wr_check,
    // tick compare
    input wire tc_read,
    input wire [1:0] tc_read_index,
    input wire [63:0] tc_tick,
    input wire [63:0] tc_stick,
    input wire [63:0] tc_entry_data,
    input wire [7:0] tc_entry_check,
    output reg [1:0] tc_scan_index,
    output reg tc_match,
    // traps
    output reg trap_precise,
    output reg trap_corrected,
    output reg trap_swrec,
    output reg trap_deferred
);

reg [10:0] rec_en;
reg [2:0] trap_en;
reg [31:0] pfs;
reg [31:0] pfa;
reg [31:0] des;
reg [31:0] dfs;

// hamming style syndrome: xor of bit positions plus overall parity
function [7:0] ecc_gen;
    input [63:0] d;
    integer i;
    reg [6:0] s;
    begin
        s = 7'h00;
        for (i = 0; i < 64; i = i + 1) begin
            if (d[i])
                s = s ^ (i[6:0] + 7'h01);
        end
        ecc_gen = {^d ^ ^s, s};
    end
endfunction

// 00 clean, 01 correctable, 10 uncorrectable
function [1:0] ecc_class;
    input [7:0] syn;
    begin
        if (syn == 8'h00)
            ecc_class = 2'h0;
        else if (syn[7])
            ecc_class = 2'h1;
        else
            ecc_class = 2'h2;
    end
endfunction

function [63:0] ecc_fix;
    input [63:0] d;
    input [7:0] syn;
    integer i;
    begin
        ecc_fix = d;
        for (i = 0; i < 64; i = i + 1) begin
            if (syn[6:0] == (i[6:0] + 7'h01))
                ecc_fix[i] = ~d[i];
        end
    end
endfunction

wire [7:0] sq_syn = ecc_gen(sq_data) ^ sq_check;
wire [7:0] sp_syn = ecc_gen(sp_data) ^ sp_check;
wire [7:0] tc_syn = ecc_gen(tc_entry_data) ^ tc_entry_check;
wire [1:0] sq_cls = ecc_class(sq_syn);
wire [1:0] sp_cls = ecc_class(sp_syn);
wire [1:0] tc_cls = ecc_class(tc_syn);
wire sq_par_err = (^sq_tag) ^ sq_tag_par;
wire irq_ok = interrupt_enable | ~hyperprivileged_flag;

// accesses qualified, diagnostic reads excluded
wire ld_ok = sq_load_hit & ~sq_diag;
wire dr_ok = (sq_drain | sq_ring) & ~sq_diag;
wire sp_ok = sp_read & ~sp_diag;
wire dr_io = sq_drain_io | sq_ring;

// load path: no CAM parity check here
wire ldc = ld_ok & (sq_cls == 2'h1) & rec_en[`CARER_REC_LDC];
wire ldu = ld_ok & (sq_cls == 2'h2) & rec_en[`CARER_REC_LDU];
// drain path; tag parity takes priority since the address is untrustworthy
wire app = dr_ok & sq_par_err & rec_en[`CARER_REC_APP];
wire dpc = dr_ok & ~app & (sq_cls == 2'h1) & rec_en[`CARER_REC_DPC];
wire dpu = dr_ok & ~app & (sq_cls == 2'h2) & rec_en[`CARER_REC_DPU] & ~dr_io;
wire iou = dr_ok & ~app & (sq_cls == 2'h2) & rec_en[`CARER_REC_DPU] & dr_io;
wire spc = sp_ok & (sp_cls == 2'h1) & rec_en[`CARER_REC_SPC];
wire spu = sp_ok & (sp_cls == 2'h2) & rec_en[`CARER_REC_SPU];
wire tcc_p = tc_read & (tc_cls == 2'h1) & rec_en[`CARER_REC_TCCP];
wire tcu_p = tc_read & (tc_cls == 2'h2) & rec_en[`CARER_REC_TCUP];
wire tcc_d = ~tc_read & (tc_cls == 2'h1) & rec_en[`CARER_REC_TCCD];
wire tcu_d = ~tc_read & (tc_cls == 2'h2) & rec_en[`CARER_REC_TCUD];
wire [1:0] tc_idx = tc_read ? tc_read_index : tc_scan_index;

// one precise event per cycle, fixed priority
reg p_hit;
reg [4:0] p_code;
reg [31:0] p_addr;
always @* begin
    p_hit = 1'b1;
    p_code = 5'h00;
    p_addr = 32'h0000_0000;
    if (ldu) begin
        p_code = `CARER_CODE_LDU;
        p_addr = {29'h0, sq_index};
    end else if (ldc) begin
        p_code = `CARER_CODE_LDC;
        p_addr = {29'h0, sq_index};
    end else if (spu) begin
        p_code = `CARER_CODE_SPU;
        p_addr = {29'h0, sp_index};
    end else if (spc) begin
        p_code = `CARER_CODE_SPC;
        p_addr = {16'h0, sp_syn, 5'h0, sp_index};
    end else if (tcu_p) begin
        p_code = `CARER_CODE_TCUP;
        p_addr = {16'h0, tc_syn, 6'h0, tc_idx};
    end else if (tcc_p) begin
        p_code = `CARER_CODE_TCCP;
        p_addr = {16'h0, tc_syn, 6'h0, tc_idx};
    end else begin
        p_hit = 1'b0;
    end
end
wire p_take = p_hit & trap_en[`CARER_TE_PRECISE];

// one disrupting log per cycle: store queue beats compare scan
reg d_hit;
reg d_swrec;
reg [4:0] d_code;
reg [7:0] d_index;
always @* begin
    d_hit = 1'b1;
    d_swrec = 1'b1;
    d_code = 5'h00;
    d_index = 8'h00;
    if (dpu) begin
        d_code = `CARER_CODE_DPU;
        d_index = {5'h0, sq_index};
    end else if (dpc) begin
        d_swrec = 1'b0;
        d_code = `CARER_CODE_DPC;
        d_index = {5'h0, sq_index};
    end else if (tcu_d) begin
        d_code = `CARER_CODE_TCUD;
        d_index = {6'h0, tc_idx};
    end else if (tcc_d) begin
        d_code = `CARER_CODE_TCCD;
        d_index = {6'h0, tc_idx};
    end else begin
        d_hit = 1'b0;
        d_swrec = 1'b0;
    end
end

wire def_hit = iou | app;
wire [31:0] reg_mask_upd = reg_wdata;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        rec_en <= `CARER_REC_RESET;
        trap_en <= `CARER_TE_RESET;
        pfs <= 32'h0000_0000;
        pfa <= 32'h0000_0000;
        des <= 32'h0000_0000;
        dfs <= 32'h0000_0000;
        reg_rdata <= 32'h0000_0000;
    end else begin
        if (reg_wr && reg_addr == `CARER_REC_EN_ADDR)
            rec_en <= reg_mask_upd[10:0];
        if (reg_wr && reg_addr == `CARER_TRAP_EN_ADDR)
            trap_en <= reg_mask_upd[2:0];
        if (p_take) begin
            pfs <= {27'h0, p_code};
            pfa <= p_addr;
        end else if (reg_wr && reg_addr == `CARER_PFS_ADDR) begin
            pfs <= reg_wdata;
        end else if (reg_wr && reg_addr == `CARER_PFA_ADDR) begin
            pfa <= reg_wdata;
        end
        // logging beats a software clear in the same cycle
        if (d_hit) begin
            des <= {1'b1, d_swrec, 17'h0, d_code, d_index};
        end else if (reg_wr && reg_addr == `CARER_DES_ADDR) begin
            des <= reg_wdata;
        end
        if (def_hit) begin
            dfs <= {1'b1, app, 12'h0, sq_priv_max, 3'h0,
                    (app ? 5'h00 : `CARER_CODE_IOU), 5'h0, sq_index};
        end else if (reg_wr && reg_addr == `CARER_DFS_ADDR) begin
            dfs <= reg_wdata;
        end
        if (reg_rd) begin
            if (reg_addr == `CARER_REC_EN_ADDR)
                reg_rdata <= {21'h0, rec_en};
            else if (reg_addr == `CARER_TRAP_EN_ADDR)
                reg_rdata <= {29'h0, trap_en};
            else if (reg_addr == `CARER_PFS_ADDR)
                reg_rdata <= pfs;
            else if (reg_addr == `CARER_PFA_ADDR)
                reg_rdata <= pfa;
            else if (reg_addr == `CARER_DES_ADDR)
                reg_rdata <= des;
            else if (reg_addr == `CARER_DFS_ADDR)
                reg_rdata <= dfs;
            else if (reg_addr == `CARER_CTRL_ADDR)
                reg_rdata <= {30'h0, tc_scan_index};
            else
                reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
end

// pending disrupting traps follow the valid flag, so a later enable presents them
wire des_v = des[`CARER_DES_VALID];
wire next_corr = des_v & ~des[`CARER_DES_SWREC] & trap_en[`CARER_TE_CORR] & irq_ok;
wire next_swrec = des_v & des[`CARER_DES_SWREC] & trap_en[`CARER_TE_DE] & irq_ok;

// store-queue data path and compare scan
wire [63:0] sq_fixed = ecc_fix(sq_data, sq_syn);
wire [63:0] cmp_src = (tc_scan_index == 2'h0) ? tc_tick : tc_stick;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        sq_out_data <= 64'h0000_0000_0000_0000;
        sq_out_poison <= 1'b0;
        sq_out_valid <= 1'b0;
        sq_suppress <= 1'b0;
        wr_check <= 8'h00;
        tc_scan_index <= 2'h0;
        tc_match <= 1'b0;
        trap_precise <= 1'b0;
        trap_corrected <= 1'b0;
        trap_swrec <= 1'b0;
        trap_deferred <= 1'b0;
    end else begin
        // forward corrected data only when the correctable case is enabled
        sq_out_data <= dpc ? sq_fixed : sq_data;
        sq_out_poison <= dpu;
        sq_out_valid <= dr_ok & ~def_hit;
        sq_suppress <= def_hit;
        wr_check <= ecc_gen(wr_data);
        // scan index wraps over the three compare entries
        if (!tc_read) begin
            if (tc_scan_index == `CARER_TC_ENTRIES - 2'h1)
                tc_scan_index <= 2'h0;
            else
                tc_scan_index <= tc_scan_index + 2'h1;
        end
        tc_match <= ~tc_read & (tc_cls == 2'h0) & (cmp_src == tc_entry_data);
        trap_precise <= p_take;
        trap_corrected <= next_corr & ~trap_corrected;
        trap_swrec <= next_swrec & ~trap_swrec;
        trap_deferred <= def_hit;
    end
end

endmodule // carer_core

// ### src/carer_regs.vh
// error codes, register offsets and field positions for the core array error reporter
`ifndef CARER_REGS_VH
`define CARER_REGS_VH
// register offsets (index into plain register port)
`define CARER_REC_EN_ADDR 4'h0
`define CARER_TRAP_EN_ADDR 4'h1
`define CARER_PFS_ADDR 4'h2
`define CARER_PFA_ADDR 4'h3
`define CARER_DES_ADDR 4'h4
`define CARER_DFS_ADDR 4'h5
`define CARER_CTRL_ADDR 4'h6
// recording enable bits
`define CARER_REC_LDC 0
`define CARER_REC_LDU 1
`define CARER_REC_DPC 2
`define CARER_REC_DPU 3
`define CARER_REC_APP 4
`define CARER_REC_SPC 5
`define CARER_REC_SPU 6
`define CARER_REC_TCCP 7
`define CARER_REC_TCUP 8
`define CARER_REC_TCCD 9
`define CARER_REC_TCUD 10
`define CARER_REC_RESET 11'h000
// trap enable bits
`define CARER_TE_PRECISE 0
`define CARER_TE_DE 1
`define CARER_TE_CORR 2
`define CARER_TE_RESET 3'h0
// error codes
`define CARER_CODE_LDC 5'h01
`define CARER_CODE_LDU 5'h02
`define CARER_CODE_DPC 5'h03
`define CARER_CODE_DPU 5'h04
`define CARER_CODE_IOU 5'h05
`define CARER_CODE_APP 5'h06
`define CARER_CODE_SPC 5'h07
`define CARER_CODE_SPU 5'h08
`define CARER_CODE_TCCP 5'h09
`define CARER_CODE_TCUP 5'h0a
`define CARER_CODE_TCCD 5'h0b
`define CARER_CODE_TCUD 5'h0c
// disrupting status layout: valid 31, sw-recoverable 30, code 12:8, index 7:0
`define CARER_DES_VALID 31
`define CARER_DES_SWREC 30
// deferred status layout: valid 31, app 30, priv 17:16, code 12:8, index 7:0
`define CARER_DFS_VALID 31
`define CARER_DFS_APP 30
`define CARER_TC_ENTRIES 2'h3
`endif

// ### bench/carer_core_assertions.sv
// checker on trap gating and store queue output relations
`timescale 1ns/10ps
module carer_core_assertions (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // register writes and accesses
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire sq_load_hit,
    input wire sp_read,
    input wire tc_read,
    // outputs
    input wire sq_out_poison,
    input wire sq_out_valid,
    input wire sq_suppress,
    input wire [1:0] tc_scan_index,
    input wire trap_precise,
    input wire trap_corrected,
    input wire trap_swrec,
    input wire trap_deferred
);
    reg [2:0] te;
    // shadow of trap enables; past value too, since the write and trap may share an edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            te <= 3'h0;
        else if (reg_wr && reg_addr == 4'h1)
            te <= reg_wdata[2:0];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_precise_cause: assert property (
        trap_precise |-> $past(sq_load_hit || sp_read || tc_read))
        else $error("precise trap without access");
    a_precise_enable: assert property (
        trap_precise |-> te[0] || $past(te[0]))
        else $error("precise trap while disabled");
    a_corr_enable: assert property (
        trap_corrected |-> te[2] || $past(te[2]))
        else $error("corrected trap while disabled");
    a_swrec_enable: assert property (
        trap_swrec |-> te[1] || $past(te[1]))
        else $error("recoverable trap while disabled");
    a_defer_suppress: assert property (
        trap_deferred |-> sq_suppress)
        else $error("deferred trap without suppress");
    a_poison_forward: assert property (
        sq_out_poison |-> sq_out_valid)
        else $error("poison without forwarded data");
    a_scan_range: assert property (
        tc_scan_index != 2'h3)
        else $error("scan index out of range");
    a_scan_moves: assert property (
        $past(rst_n, 3) && !$past(tc_read) && !$past(tc_read, 2)
        |-> tc_scan_index != $past(tc_scan_index))
        else $error("scan index stuck");
    c_deferred: cover property (trap_deferred);
    c_corrected: cover property (trap_corrected);
    c_poison: cover property (sq_out_poison);
endmodule // carer_core_assertions
bind carer_core carer_core_assertions carer_core_assertions_inst (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .sq_load_hit, .sp_read, .tc_read,
    .sq_out_poison, .sq_out_valid, .sq_suppress, .tc_scan_index, .trap_precise,
    .trap_corrected, .trap_swrec, .trap_deferred
);

// ### bench/carer_sink.sv
// trap unit stand-in: counts precise trap requests
`timescale 1ns/10ps
module carer_sink (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // from the reporter
    input wire trap_precise,
    // seen so far
    output reg [7:0] n_precise
);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            n_precise <= 8'h00;
        else
            n_precise <= n_precise + {7'h00, trap_precise};
    end
endmodule // carer_sink

// ### bench/carer_core_tb.sv
// self-checking bench for the core array error reporter
`timescale 1ns/10ps
module carer_core_tb;
    localparam [63:0] D = 64'h0123_4567_89ab_cdef;
    localparam [63:0] E1 = 64'h0000_0000_0000_0020;
    localparam [63:0] E2 = 64'h0000_0000_0000_0003;
    localparam [39:0] TAG = 40'h12_3456_789a;
    localparam [31:0] ALL = 32'hffff_ffff;
    reg core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg ie = 1'b0, hp = 1'b1, sq_tag_par = ^TAG;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0000_0000;
    reg [7:0] acc = 8'h00;
    reg [2:0] idx = 3'h0;
    reg [1:0] priv = 2'h0;
    reg [63:0] sq_data = D, sp_data = D, wr_data = D, tc_data = D;
    wire [7:0] good = ecc(D);
    wire [31:0] reg_rdata;
    wire [63:0] sq_out_data;
    wire [7:0] wr_check, n_precise;
    wire [1:0] tc_scan_index;
    wire tc_match;
    wire [3:0] traps;
    wire sq_out_poison, sq_out_valid, sq_suppress;
    integer errors = 0, total_checks = 0;
    carer_core carer_core_inst (
        .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .interrupt_enable(ie), .hyperprivileged_flag(hp),
        .sq_load_hit(acc[0]), .sq_drain(acc[1]), .sq_drain_io(acc[2]), .sq_ring(acc[3]),
        .sq_diag(acc[4]), .sq_index(idx), .sq_data, .sq_check(good), .sq_tag(TAG),
        .sq_tag_par, .sq_priv_valid(4'hf), .sq_priv_max(priv), .sq_out_data,
        .sq_out_poison, .sq_out_valid, .sq_suppress, .sp_read(acc[5]), .sp_diag(acc[6]),
        .sp_index(idx), .sp_data, .sp_check(good), .wr_data, .wr_check, .tc_read(acc[7]),
        .tc_read_index(2'h1), .tc_tick(D), .tc_stick(D), .tc_entry_data(tc_data),
        .tc_entry_check(good), .tc_scan_index, .tc_match, .trap_precise(traps[0]),
        .trap_corrected(traps[1]), .trap_swrec(traps[2]), .trap_deferred(traps[3])
    );
    carer_sink carer_sink_inst (.core_clk, .rst_n, .trap_precise(traps[0]), .n_precise);
    function [7:0] ecc(input [63:0] d);
        reg [6:0] s;
        integer i;
        begin
            s = 7'h00;
            for (i = 0; i < 64; i = i + 1)
                if (d[i]) s = s ^ (i[6:0] + 7'h01);
            ecc = {^d ^ ^s, s};
        end
    endfunction
    task cmp(input [63:0] got, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1;
            cmp({32'h0000_0000, reg_rdata & m}, {32'h0000_0000, e});
        end
    endtask
    // one-cycle access pulse; returns just after the edge that answers it
    task go(input [7:0] a);
        begin
            @(posedge core_clk);
            acc <= a;
            @(posedge core_clk);
            acc <= 8'h00;
            #1;
        end
    endtask
    // pending traps toggle, so look over several cycles
    task watch(input [3:0] m, input e);
        reg hit;
        integer k;
        begin
            hit = 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                hit = hit | (|(traps & m));
                @(posedge core_clk);
                #1;
            end
            cmp({63'h0, hit}, {63'h0, e});
        end
    endtask
    task t_load;
        reg [7:0] n;
        begin
            wr(4'h0, 32'h0000_0001);
            idx <= 3'h5;
            sq_data <= D ^ E1;
            go(8'h01);
            watch(4'h1, 1'b0);
            rd(4'h2, ALL, 32'h0000_0000);
            wr(4'h1, 32'h0000_0001);
            n = n_precise;
            go(8'h01);
            watch(4'h1, 1'b1);
            cmp({56'h0, n_precise - n}, 64'h1);
            rd(4'h2, ALL, 32'h0000_0001);
            rd(4'h3, 32'h0000_00ff, 32'h0000_0005);
            // load hit with a live single-bit error, but marked diagnostic
            go(8'h11);
            watch(4'hf, 1'b0);
            sq_data <= D ^ E2;
            go(8'h01);
            watch(4'h1, 1'b0);
            // tag parity recording on too, so the load path must ignore the bad parity
            wr(4'h0, 32'h0000_0013);
            go(8'h01);
            watch(4'h1, 1'b1);
            rd(4'h2, ALL, 32'h0000_0002);
            sq_data <= D;
            sq_tag_par <= ~^TAG;
            go(8'h01);
            watch(4'h1, 1'b0);
            sq_tag_par <= ^TAG;
            $display("t_load done");
        end
    endtask
    task t_drain;
        begin
            wr(4'h0, 32'h0000_000c);
            wr(4'h1, 32'h0000_0000);
            idx <= 3'h3;
            sq_data <= D ^ E1;
            go(8'h02);
            cmp(sq_out_data, D);
            rd(4'h4, ALL, 32'h8000_0303);
            wr(4'h1, 32'h0000_0004);
            watch(4'h2, 1'b0);
            hp <= 1'b0;
            watch(4'h2, 1'b1);
            wr(4'h4, 32'h0000_0000);
            sq_data <= D ^ E2;
            go(8'h02);
            cmp({63'h0, sq_out_poison}, 64'h1);
            rd(4'h4, 32'h8000_1fff, 32'h8000_0403);
            watch(4'h4, 1'b0);
            wr(4'h1, 32'h0000_0002);
            watch(4'h4, 1'b1);
            wr(4'h4, 32'h0000_0000);
            $display("t_drain done");
        end
    endtask
    task t_store;
        begin
            wr(4'h0, 32'h0000_0018);
            priv <= 2'h2;
            go(8'h06);
            cmp({63'h0, sq_suppress}, 64'h1);
            cmp({63'h0, sq_out_valid}, 64'h0);
            watch(4'h8, 1'b1);
            rd(4'h5, ALL, 32'h8002_0503);
            wr(4'h5, 32'h0000_0000);
            sq_data <= D;
            sq_tag_par <= ~^TAG;
            priv <= 2'h1;
            go(8'h08);
            cmp({63'h0, sq_suppress}, 64'h1);
            rd(4'h5, ALL, 32'hc001_0003);
            sq_tag_par <= ^TAG;
            $display("t_store done");
        end
    endtask
    task t_array;
        begin
            wr(4'h0, 32'h0000_02a0);
            wr(4'h1, 32'h0000_0001);
            idx <= 3'h2;
            sp_data <= D ^ E1;
            // normal read strobe beside the diagnostic qualifier
            go(8'h60);
            watch(4'h1, 1'b0);
            go(8'h20);
            watch(4'h1, 1'b1);
            rd(4'h2, ALL, 32'h0000_0007);
            rd(4'h3, 32'h0000_ffff, 32'h0000_8602);
            wr_data <= D ^ E2;
            @(posedge core_clk);
            #1;
            cmp({56'h0, wr_check}, {56'h0, ecc(D ^ E2)});
            cmp({63'h0, tc_match}, 64'h1);
            wr(4'h4, 32'h0000_0000);
            tc_data <= D ^ E1;
            @(posedge core_clk);
            @(posedge core_clk);
            #1;
            cmp({63'h0, tc_match}, 64'h0);
            go(8'h80);
            watch(4'h1, 1'b1);
            rd(4'h2, ALL, 32'h0000_0009);
            rd(4'h4, 32'h8000_1f00, 32'h8000_0b00);
            wr(4'h1, 32'h0000_0002);
            watch(4'h4, 1'b1);
            tc_data <= D;
            $display("t_array done");
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(4'h0, ALL, 32'h0000_0000);
        rd(4'h1, ALL, 32'h0000_0000);
        rd(4'hf, ALL, 32'h0000_0000);
        t_load;
        t_drain;
        t_store;
        t_array;
        test_done;
    end
    // the tests need well under a thousand cycles
    initial begin
        #20000;
        errors = errors + 1;
        test_done;
    end
endmodule // carer_core_tb
